// ### design/ebc_area_decode.sv
// Area and internal-region decoder for the external bus controller
`timescale 1ns/100ps
module ebc_area_decode
   import ebc_pkg::*;
(
   input  wire logic [23:0] addr,
   input  wire logic        mode_16m,
   input  wire logic        ram_enable,
   output logic      [2:0]  area,
   output logic             internal
);
   logic [23:0] a_1m;
   logic        in_ram;
   logic        in_regs;

   assign a_1m = {4'h0, addr[19:0] & ADDR_MASK_1M};

   always_comb begin
      // Upper address bits pick one of eight equal areas
      area = mode_16m ? addr[AREA_MSB_16M -: 3] : addr[AREA_MSB_1M -: 3];
      if (mode_16m) begin
         in_ram  = (addr >= RAM_LO_16M) && (addr <= RAM_HI_16M);
         in_regs = (addr >= REGS_LO_16M);
      end else begin
         in_ram  = (a_1m >= RAM_LO_1M) && (a_1m <= RAM_HI_1M);
         in_regs = (a_1m >= REGS_LO_1M);
      end
      // Disabled RAM and the gap fall through to area 7 as external
      internal = (in_ram && ram_enable) || in_regs;
   end
endmodule

// ### design/ebc_bus_ctrl.sv
// External area bus controller: area decode, wait states, strobes, selects
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module ebc_bus_ctrl
   import ebc_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        RESET,
   input  wire logic [2:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [7:0]  REG_RDATA,
   input  wire logic        MODE_16M,
   input  wire logic        REQ,
   input  wire logic [23:0] REQ_ADDR,
   input  wire logic        REQ_WRITE,
   input  wire logic        REQ_WORD,
   input  wire logic [15:0] REQ_WDATA,
   output logic             BUSY,
   output logic             DONE,
   output logic      [15:0] RDATA,
   output logic      [23:0] ADDR,
   input  wire logic [15:0] DATA_IN,
   output logic      [15:0] DATA_OUT,
   output logic             DATA_OE_HI,
   output logic             DATA_OE_LO,
   output logic             RD_N,
   output logic             HIGH_BYTE_WRITE_STROBE_N,
   output logic             LOW_BYTE_WRITE_STROBE_N,
   input  wire logic        WAIT_N,
   output logic      [3:0]  AREA_SELECT_N,
   output logic      [3:0]  AREA_SELECT_OE
);
   logic [7:0]  area_width_sel_q;
   logic [7:0]  area_three_state_sel_q;
   logic [7:0]  area_wait_ctrl_en_q;
   logic [1:0]  wait_mode_q;
   logic [1:0]  wait_count_q;
   logic        internal_ram_enable_q;
   logic [3:0]  sel_dir_q;
   logic [7:0]  reg_rdata_q;
   logic        wait_s1_q, wait_s2_q, wait_s3_q, wait_low_q;
   ebc_state_t  state_q, state_d;
   logic [1:0]  wcnt_q, wcnt_d;
   logic [23:0] addr_q;
   logic [2:0]  area_q;
   logic        internal_q, wide_q, three_q, wce_q, write_q, word_q, split_q;
   ebc_wmode_t  wmode_q;
   logic [1:0]  count_q;
   logic [15:0] wdata_q;
   logic        fin_q, done_q, busy_q;
   logic [15:0] rdata_q;
   logic [2:0]  dec_area;
   logic        dec_internal;
   logic        final_state;
   logic        rd_n_q, hwr_n_q, lwr_n_q, oe_hi_q, oe_lo_q;
   logic [15:0] dout_q;
   logic [3:0]  sel_n_q;

   ebc_area_decode u_decode (
      .addr       (REQ_ADDR),
      .mode_16m   (MODE_16M),
      .ram_enable (internal_ram_enable_q),
      .area       (dec_area),
      .internal   (dec_internal)
   );

   // Control registers
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         area_width_sel_q       <= RST_WIDTH;
         area_three_state_sel_q <= RST_STATES;
         area_wait_ctrl_en_q    <= RST_WAITEN;
         wait_mode_q            <= RST_WMODE;
         wait_count_q           <= RST_WCOUNT;
         internal_ram_enable_q  <= RST_RAMEN;
         sel_dir_q              <= RST_SELDIR;
      end else if (REG_WR) begin
         unique case (REG_ADDR)
            REG_WIDTH:  area_width_sel_q       <= REG_WDATA;
            REG_STATES: area_three_state_sel_q <= REG_WDATA;
            REG_WAITEN: area_wait_ctrl_en_q    <= REG_WDATA;
            REG_WAIT:   {wait_mode_q, wait_count_q} <= REG_WDATA[3:0];
            REG_SYSCTL: internal_ram_enable_q  <= REG_WDATA[0];
            // Select 0 always drives
            REG_SELDIR: sel_dir_q <= {REG_WDATA[3:1], RST_SELDIR[0]};
            default: ;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         reg_rdata_q <= 8'h00;
      end else if (REG_RD) begin
         unique case (REG_ADDR)
            REG_WIDTH:  reg_rdata_q <= area_width_sel_q;
            REG_STATES: reg_rdata_q <= area_three_state_sel_q;
            REG_WAITEN: reg_rdata_q <= area_wait_ctrl_en_q;
            REG_WAIT:   reg_rdata_q <= {WAIT_RSVD, wait_mode_q, wait_count_q};
            REG_SYSCTL: reg_rdata_q <= {7'h00, internal_ram_enable_q};
            REG_SELDIR: reg_rdata_q <= {4'h0, sel_dir_q};
            REG_STATUS: reg_rdata_q <= {3'h0, internal_q, area_q, busy_q};
            default:    reg_rdata_q <= 8'h00;
         endcase
      end else begin
         reg_rdata_q <= 8'h00;
      end
   end

   // Wait request synchroniser; a level counts once stages two and three agree
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         wait_s1_q  <= 1'b1;
         wait_s2_q  <= 1'b1;
         wait_s3_q  <= 1'b1;
         wait_low_q <= 1'b0;
      end else begin
         wait_s1_q <= WAIT_N;
         wait_s2_q <= wait_s1_q;
         wait_s3_q <= wait_s2_q;
         if (wait_s2_q == wait_s3_q) begin
            wait_low_q <= ~wait_s3_q;
         end
      end
   end

   assign final_state = (state_q == ST_T3) || (state_q == ST_T2 && !three_q);

   // Access sequencer
   always_comb begin
      state_d = state_q;
      wcnt_d  = wcnt_q;
      unique case (state_q)
         ST_IDLE: if (REQ && !fin_q) begin
            state_d = ST_T1;
         end
         ST_T1: state_d = ST_T2;
         ST_T2: begin
            if (!three_q) begin
               state_d = split_q ? ST_T1 : ST_IDLE;
            end else if (!wce_q) begin
               state_d = wait_low_q ? ST_TW : ST_T3;
               wcnt_d  = 2'h1;
            end else begin
               unique case (wmode_q)
                  WM_PROG: begin
                     state_d = (count_q != 2'h0) ? ST_TW : ST_T3;
                     wcnt_d  = count_q;
                  end
                  WM_NONE: state_d = ST_T3;
                  WM_PIN1: begin
                     // Count of zero behaves like pin wait mode 0
                     state_d = (count_q != 2'h0 || wait_low_q) ? ST_TW : ST_T3;
                     wcnt_d  = (count_q != 2'h0) ? count_q : 2'h1;
                  end
                  WM_AUTO: begin
                     state_d = (wait_low_q && count_q != 2'h0) ? ST_TW : ST_T3;
                     wcnt_d  = count_q;
                  end
               endcase
            end
         end
         ST_TW: begin
            if (wcnt_q > 2'h1) begin
               wcnt_d = wcnt_q - 2'h1;
            end else if ((!wce_q || wmode_q == WM_PIN1) && wait_low_q) begin
               state_d = ST_TW;
            end else begin
               state_d = ST_T3;
            end
         end
         ST_T3: state_d = split_q ? ST_T1 : ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         state_q <= ST_IDLE;
         wcnt_q  <= 2'h0;
      end else begin
         state_q <= state_d;
         wcnt_q  <= wcnt_d;
      end
   end

   // Access attributes latched at acceptance; a word to an 8-bit area runs as two bytes
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         addr_q <= 24'h000000;
         area_q <= 3'h0;
         {internal_q, wide_q, three_q, wce_q, write_q, word_q, split_q} <= 7'h00;
         wmode_q <= WM_PROG;
         count_q <= 2'h0;
         wdata_q <= 16'h0000;
      end else if (state_q == ST_IDLE && REQ && !fin_q) begin
         addr_q     <= REQ_ADDR;
         area_q     <= dec_area;
         internal_q <= dec_internal;
         // Internal accesses run fixed two-state on the full width
         wide_q     <= dec_internal || !area_width_sel_q[dec_area];
         three_q    <= !dec_internal && area_three_state_sel_q[dec_area];
         wce_q      <= area_wait_ctrl_en_q[dec_area];
         wmode_q    <= ebc_wmode_t'(wait_mode_q);
         count_q    <= wait_count_q;
         write_q    <= REQ_WRITE;
         word_q     <= REQ_WORD;
         split_q    <= REQ_WORD && !dec_internal && area_width_sel_q[dec_area];
         wdata_q    <= REQ_WDATA;
      end else if (fin_q && split_q) begin
         // Address moves on only after the first byte has been sampled or written
         addr_q  <= addr_q | 24'h000001;
         split_q <= 1'b0;
      end
   end

   // Completion: data sampled while the pins still show the last state
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         fin_q   <= 1'b0;
         done_q  <= 1'b0;
         busy_q  <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         fin_q  <= final_state;
         done_q <= fin_q && !split_q && (state_q != ST_T2 || !three_q);
         busy_q <= (state_d != ST_IDLE) || final_state || fin_q;
         if (fin_q && !write_q) begin
            if (internal_q) begin
               rdata_q <= 16'h0000;
            end else if (!wide_q) begin
               // Only the upper half carries data in 8-bit areas
               if (word_q && addr_q[0]) begin
                  rdata_q[7:0] <= DATA_IN[15:8];
               end else if (word_q) begin
                  rdata_q[15:8] <= DATA_IN[15:8];
               end else begin
                  rdata_q <= {8'h00, DATA_IN[15:8]};
               end
            end else if (word_q) begin
               rdata_q <= DATA_IN;
            end else begin
               rdata_q <= {8'h00, addr_q[0] ? DATA_IN[7:0] : DATA_IN[15:8]};
            end
         end
      end
   end

   // Pin drivers, registered from the sequencer state
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         rd_n_q  <= 1'b1;
         hwr_n_q <= 1'b1;
         lwr_n_q <= 1'b1;
         oe_hi_q <= 1'b0;
         oe_lo_q <= 1'b0;
         dout_q  <= 16'h0000;
         sel_n_q <= 4'hf;
      end else begin
         rd_n_q  <= !(state_q != ST_IDLE && !internal_q && !write_q);
         hwr_n_q <= 1'b1;
         lwr_n_q <= 1'b1;
         oe_hi_q <= 1'b0;
         oe_lo_q <= 1'b0;
         dout_q  <= 16'h0000;
         if (state_q != ST_IDLE && !internal_q && write_q) begin
            if (!wide_q) begin
               // Low strobe stays high in 8-bit areas
               oe_hi_q <= 1'b1;
               dout_q  <= {(word_q && !addr_q[0]) ? wdata_q[15:8] : wdata_q[7:0], 8'h00};
               hwr_n_q <= (state_q == ST_T1);
            end else if (word_q) begin
               oe_hi_q <= 1'b1;
               oe_lo_q <= 1'b1;
               dout_q  <= wdata_q;
               hwr_n_q <= (state_q == ST_T1);
               lwr_n_q <= (state_q == ST_T1);
            end else if (addr_q[0]) begin
               oe_lo_q <= 1'b1;
               dout_q  <= {8'h00, wdata_q[7:0]};
               lwr_n_q <= (state_q == ST_T1);
            end else begin
               oe_hi_q <= 1'b1;
               dout_q  <= {wdata_q[7:0], 8'h00};
               hwr_n_q <= (state_q == ST_T1);
            end
         end
         // Select of areas 0 to 3 follows the decoded area for the whole cycle including waits
         sel_n_q <= 4'hf;
         if (state_q != ST_IDLE && !internal_q && area_q[2] == 1'b0) begin
            sel_n_q[area_q[1:0]] <= 1'b0;
         end
      end
   end

   assign REG_RDATA                = reg_rdata_q;
   assign BUSY                     = busy_q;
   assign DONE                     = done_q;
   assign RDATA                    = rdata_q;
   assign ADDR                     = addr_q;
   assign DATA_OUT                 = dout_q;
   assign DATA_OE_HI               = oe_hi_q;
   assign DATA_OE_LO               = oe_lo_q;
   assign RD_N                     = rd_n_q;
   assign HIGH_BYTE_WRITE_STROBE_N = hwr_n_q;
   assign LOW_BYTE_WRITE_STROBE_N  = lwr_n_q;
   assign AREA_SELECT_N            = sel_n_q;
   assign AREA_SELECT_OE           = sel_dir_q;

   property p_two_state_no_wait;
      @(posedge CORE_CLK) disable iff (RESET) (state_q == ST_TW) |-> three_q;
   endproperty
   a_two_state_no_wait: assert property (p_two_state_no_wait) else $error("wait in two-state area");

   property p_lwr_8bit;
      @(posedge CORE_CLK) disable iff (RESET)
         (state_q != ST_IDLE && !wide_q) |=> LOW_BYTE_WRITE_STROBE_N;
   endproperty
   a_lwr_8bit: assert property (p_lwr_8bit) else $error("low strobe active in 8-bit area");

   property p_prog_three;
      @(posedge CORE_CLK) disable iff (RESET)
         (state_q == ST_T2 && three_q && wce_q && wmode_q == WM_PROG && count_q == 2'h3)
         |=> (state_q == ST_TW) [*3] ##1 (state_q == ST_T3);
   endproperty
   a_prog_three: assert property (p_prog_three) else $error("programmable wait count wrong");

   property p_auto_one;
      @(posedge CORE_CLK) disable iff (RESET)
         (state_q == ST_T2 && three_q && wce_q && wmode_q == WM_AUTO && count_q == 2'h1
          && wait_low_q) |=> (state_q == ST_TW) ##1 (state_q == ST_T3);
   endproperty
   a_auto_one: assert property (p_auto_one) else $error("auto-wait inserted wrong count");

   property p_pin1_hold;
      @(posedge CORE_CLK) disable iff (RESET)
         (state_q == ST_TW && wcnt_q == 2'h1 && wce_q && wmode_q == WM_PIN1 && wait_low_q)
         |=> (state_q == ST_TW);
   endproperty
   a_pin1_hold: assert property (p_pin1_hold) else $error("pin wait 1 did not extend");

   property p_sel0_hold;
      @(posedge CORE_CLK) disable iff (RESET)
         (state_q != ST_IDLE && !internal_q && area_q == 3'h0) |=> !AREA_SELECT_N[0];
   endproperty
   a_sel0_hold: assert property (p_sel0_hold) else $error("area 0 select not held");

   property p_word_both;
      @(posedge CORE_CLK) disable iff (RESET)
         (state_q == ST_T2 && write_q && word_q && wide_q && !internal_q)
         |=> (!HIGH_BYTE_WRITE_STROBE_N && !LOW_BYTE_WRITE_STROBE_N);
   endproperty
   a_word_both: assert property (p_word_both) else $error("word write strobes not paired");

   property p_read_strobe;
      @(posedge CORE_CLK) disable iff (RESET)
         (state_q == ST_T2 && !write_q && !internal_q)
         |=> (!RD_N && HIGH_BYTE_WRITE_STROBE_N && LOW_BYTE_WRITE_STROBE_N
              && !DATA_OE_HI && !DATA_OE_LO);
   endproperty
   a_read_strobe: assert property (p_read_strobe) else $error("read strobing wrong");

   property p_odd_byte;
      @(posedge CORE_CLK) disable iff (RESET)
         (state_q == ST_T2 && write_q && !word_q && wide_q && !internal_q && addr_q[0])
         |=> (!LOW_BYTE_WRITE_STROBE_N && HIGH_BYTE_WRITE_STROBE_N);
   endproperty
   a_odd_byte: assert property (p_odd_byte) else $error("odd byte write strobe wrong");

   property p_internal_quiet;
      @(posedge CORE_CLK) disable iff (RESET)
         (state_q != ST_IDLE && internal_q) |=> (RD_N && AREA_SELECT_N == 4'hf);
   endproperty
   a_internal_quiet: assert property (p_internal_quiet) else $error("internal access on pins");

   property p_reset_dir;
      @(posedge CORE_CLK) RESET |=> (AREA_SELECT_OE == RST_SELDIR);
   endproperty
   a_reset_dir: assert property (p_reset_dir) else $error("select direction after reset");

   c_prog_wait: cover property (@(posedge CORE_CLK) disable iff (RESET)
      state_q == ST_TW && wmode_q == WM_PROG);
   c_pin1_extend: cover property (@(posedge CORE_CLK) disable iff (RESET)
      state_q == ST_TW && wmode_q == WM_PIN1 && wcnt_q == 2'h1 && wait_low_q);
   c_split_word: cover property (@(posedge CORE_CLK) disable iff (RESET)
      final_state && split_q);
   c_internal: cover property (@(posedge CORE_CLK) disable iff (RESET)
      state_q == ST_T2 && internal_q);
endmodule

// ### design/ebc_pkg.sv
// Constants, types and register map of the external area bus controller
package ebc_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_T1, ST_T2, ST_TW, ST_T3} ebc_state_t;
   typedef enum logic [1:0] {WM_PROG, WM_NONE, WM_PIN1, WM_AUTO} ebc_wmode_t;

   // Register indices on the control port
   localparam logic [2:0] REG_WIDTH  = 3'h0;
   localparam logic [2:0] REG_STATES = 3'h1;
   localparam logic [2:0] REG_WAITEN = 3'h2;
   localparam logic [2:0] REG_WAIT   = 3'h3;
   localparam logic [2:0] REG_SYSCTL = 3'h4;
   localparam logic [2:0] REG_SELDIR = 3'h5;
   localparam logic [2:0] REG_STATUS = 3'h6;

   localparam logic [7:0] RST_WIDTH  = 8'hff;
   localparam logic [7:0] RST_STATES = 8'hff;
   localparam logic [7:0] RST_WAITEN = 8'hff;
   localparam logic [1:0] RST_WMODE  = 2'h0;
   localparam logic [1:0] RST_WCOUNT = 2'h3;
   localparam logic [3:0] WAIT_RSVD  = 4'hf;
   localparam logic       RST_RAMEN  = 1'b1;
   localparam logic [3:0] RST_SELDIR = 4'h1;

   // Area number position in the address
   localparam int AREA_MSB_1M  = 19;
   localparam int AREA_MSB_16M = 23;

   // Internal region limits, 1-Mbyte and 16-Mbyte modes
   localparam logic [23:0] RAM_LO_1M   = 24'h0fef10;
   localparam logic [23:0] RAM_HI_1M   = 24'h0fff0f;
   localparam logic [23:0] REGS_LO_1M  = 24'h0fff1c;
   localparam logic [23:0] RAM_LO_16M  = 24'hffef10;
   localparam logic [23:0] RAM_HI_16M  = 24'hffff0f;
   localparam logic [23:0] REGS_LO_16M = 24'hffff1c;
   localparam logic [19:0] ADDR_MASK_1M = 20'hfffff;
endpackage

// ### dv/ebc_ext_mem.sv
// Behavioural model of the external memories on the controller's far side
`timescale 1ns/100ps
module ebc_ext_mem (
   input  wire logic        clk,
   input  wire logic [23:0] addr,
   input  wire logic [15:0] wdata,
   input  wire logic        rd_n,
   input  wire logic        high_byte_write_strobe_n,
   input  wire logic        low_byte_write_strobe_n,
   input  wire logic        oe_hi,
   input  wire logic        oe_lo,
   input  wire logic        stall,
   output logic      [15:0] rdata,
   output logic             wait_n
);
   logic [7:0] byte8 [256];
   logic [7:0] hi    [128];
   logic [7:0] lo    [128];
   logic       narrow;
   logic       flip_q = 1'b0;

   // Address bits 19 to 17 equal to 2 (area 2 in 1-Mbyte mode) hold an 8-bit device, any other value a 16-bit one
   assign narrow = (addr[19:17] == 3'h2);
   assign wait_n = ~stall;

   initial begin
      foreach (byte8[i]) byte8[i] = 8'h00;
      foreach (hi[i]) hi[i] = 8'h00;
      foreach (lo[i]) lo[i] = 8'h00;
   end

   always @(posedge clk) begin
      flip_q <= ~flip_q;
      if (!high_byte_write_strobe_n && oe_hi && narrow) byte8[addr[7:0]] <= wdata[15:8];
      if (!high_byte_write_strobe_n && oe_hi && !narrow) hi[addr[7:1]] <= wdata[15:8];
      if (!low_byte_write_strobe_n && oe_lo && !narrow) lo[addr[7:1]] <= wdata[7:0];
   end

   // Lanes not driven toggle each cycle so stale data never passes for a read
   always_comb begin
      rdata = {16{flip_q}} ^ 16'h5aa5;
      if (!rd_n && narrow) rdata[15:8] = byte8[addr[7:0]];
      if (!rd_n && !narrow) rdata = {hi[addr[7:1]], lo[addr[7:1]]};
   end
endmodule

// ### dv/external_area_bus_controller_test.sv
// Self-checking bench for the external area bus controller
`timescale 1ns/100ps
module external_area_bus_controller_test;
   import ebc_pkg::*;
   typedef struct {logic m16; logic ram; logic [7:0] wait_ctrl_reg; logic st; logic [23:0] a;
                   logic wr; logic wd; logic [15:0] wdat; logic [15:0] exp; int cyc;
                   logic [3:0] sel; logic [2:0] strb;} ebc_row_t;
   logic        CORE_CLK = 1'b0;
   logic        RESET = 1'b1;
   logic [2:0]  REG_ADDR = 3'h0;
   logic [7:0]  REG_WDATA = 8'h00;
   logic        REG_WR = 1'b0;
   logic        REG_RD = 1'b0;
   logic [7:0]  REG_RDATA;
   logic        MODE_16M = 1'b0;
   logic        REQ = 1'b0;
   logic [23:0] REQ_ADDR = 24'h000000;
   logic        REQ_WRITE = 1'b0;
   logic        REQ_WORD = 1'b0;
   logic [15:0] REQ_WDATA = 16'h0000;
   logic        BUSY, DONE, DATA_OE_HI, DATA_OE_LO, RD_N, WAIT_N;
   logic        HIGH_BYTE_WRITE_STROBE_N, LOW_BYTE_WRITE_STROBE_N;
   logic [15:0] RDATA, DATA_IN, DATA_OUT;
   logic [23:0] ADDR;
   logic [3:0]  AREA_SELECT_N, AREA_SELECT_OE;
   logic        stall = 1'b0;
   int          miscompares = 0;
   int          checked = 0;
   int          cycles = 0;
   ebc_row_t    rows [20];
   logic [7:0]  rst_val [8] = '{8'hff, 8'hff, 8'hff, 8'hf3, 8'h01, 8'h01, 8'h00, 8'h00};
   logic [15:0] d;
   int          n;
   logic [3:0]  s;
   logic [2:0]  t;

   always #5 CORE_CLK = ~CORE_CLK;

   ebc_bus_ctrl uut (.CORE_CLK, .RESET, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
      .MODE_16M, .REQ, .REQ_ADDR, .REQ_WRITE, .REQ_WORD, .REQ_WDATA, .BUSY, .DONE, .RDATA,
      .ADDR, .DATA_IN, .DATA_OUT, .DATA_OE_HI, .DATA_OE_LO, .RD_N, .HIGH_BYTE_WRITE_STROBE_N,
      .LOW_BYTE_WRITE_STROBE_N, .WAIT_N, .AREA_SELECT_N, .AREA_SELECT_OE);

   ebc_ext_mem mem (.clk(CORE_CLK), .addr(ADDR), .wdata(DATA_OUT), .rd_n(RD_N),
      .high_byte_write_strobe_n(HIGH_BYTE_WRITE_STROBE_N),
      .low_byte_write_strobe_n(LOW_BYTE_WRITE_STROBE_N), .oe_hi(DATA_OE_HI),
      .oe_lo(DATA_OE_LO), .stall(stall), .rdata(DATA_IN),
      .wait_n(WAIT_N));

   task automatic end_of_test();
      if (miscompares == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   always @(posedge CORE_CLK) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end

   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wreg(logic [2:0] idx, logic [7:0] v);
      @(posedge CORE_CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= idx;
      REG_WDATA <= v;
      @(posedge CORE_CLK);
      REG_WR <= 1'b0;
   endtask

   task automatic rreg(logic [2:0] idx, logic [7:0] e);
      @(posedge CORE_CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= idx;
      @(posedge CORE_CLK);
      REG_RD <= 1'b0;
      @(posedge CORE_CLK);
      chk("reg_rdata", {8'h00, e}, {8'h00, REG_RDATA});
   endtask

   // Runs one access and collects the lowest levels seen on selects and strobes
   task automatic acc(ebc_row_t r, output logic [15:0] rd, output int k,
                      output logic [3:0] sl, output logic [2:0] st);
      @(posedge CORE_CLK);
      while (BUSY !== 1'b0) @(posedge CORE_CLK);
      REQ <= 1'b1;
      REQ_ADDR <= r.a;
      REQ_WRITE <= r.wr;
      REQ_WORD <= r.wd;
      REQ_WDATA <= r.wdat;
      k = 0;
      sl = 4'hf;
      st = 3'h7;
      do begin
         @(posedge CORE_CLK);
         REQ <= 1'b0;
         k++;
         sl &= AREA_SELECT_N;
         st &= {RD_N, HIGH_BYTE_WRITE_STROBE_N, LOW_BYTE_WRITE_STROBE_N};
      end while (DONE !== 1'b1 && k < 200);
      rd = RDATA;
      k = k - 1;
   endtask

   initial begin
      rows = '{'{0, 1, 8'hf1, 0, 24'h000010, 1, 1, 16'h1234, 16'h0, 4, 4'he, 3'h4},
         '{0, 1, 8'hf1, 0, 24'h000010, 0, 1, 16'h0, 16'h1234, 4, 4'he, 3'h3},
         '{0, 1, 8'hf1, 0, 24'h000011, 0, 0, 16'h0, 16'h0034, 4, 4'he, 3'h3},
         '{0, 1, 8'hf1, 0, 24'h000013, 1, 0, 16'h00ab, 16'h0, 4, 4'he, 3'h6},
         '{0, 1, 8'hf1, 0, 24'h000014, 1, 0, 16'h00cd, 16'h0, 4, 4'he, 3'h5},
         '{0, 1, 8'hf1, 0, 24'h000012, 0, 1, 16'h0, 16'h00ab, 4, 4'he, 3'h3},
         '{0, 1, 8'hf1, 0, 24'h000014, 0, 1, 16'h0, 16'hcd00, 4, 4'he, 3'h3},
         '{0, 1, 8'hf2, 0, 24'h040004, 1, 0, 16'h005c, 16'h0, 7, 4'hb, 3'h5},
         '{0, 1, 8'hf3, 0, 24'h040004, 0, 0, 16'h0, 16'h005c, 8, 4'hb, 3'h3},
         '{0, 1, 8'hf0, 0, 24'h040006, 1, 1, 16'ha1b2, 16'h0, 8, 4'hb, 3'h5},
         '{0, 1, 8'hf0, 0, 24'h040006, 0, 1, 16'h0, 16'ha1b2, 8, 4'hb, 3'h3},
         '{0, 1, 8'hf5, 0, 24'h060020, 0, 0, 16'h0, 16'h0, 5, 4'h7, 3'h3},
         '{0, 1, 8'hf7, 0, 24'h060020, 0, 0, 16'h0, 16'h0, 5, 4'h7, 3'h3},
         '{0, 1, 8'hfd, 1, 24'h060020, 0, 0, 16'h0, 16'h0, 6, 4'h7, 3'h3},
         '{0, 1, 8'hf7, 1, 24'h000010, 0, 1, 16'h0, 16'h1234, 4, 4'he, 3'h3},
         '{0, 1, 8'hf1, 0, 24'h0ff010, 0, 1, 16'h0, 16'h0, 4, 4'hf, 3'h7},
         '{0, 0, 8'hf1, 0, 24'h0ff010, 0, 1, 16'h0, 16'h1234, 4, 4'hf, 3'h3},
         '{0, 1, 8'hf1, 0, 24'h0fff12, 1, 1, 16'h7788, 16'h0, 4, 4'hf, 3'h4},
         '{0, 1, 8'hf1, 0, 24'h0fff12, 0, 1, 16'h0, 16'h7788, 4, 4'hf, 3'h3},
         '{1, 1, 8'hf7, 0, 24'h200010, 0, 1, 16'h0, 16'h1234, 4, 4'hd, 3'h3}};
      repeat (4) @(posedge CORE_CLK);
      RESET <= 1'b0;
      chk("select_oe", 16'h0001, {12'h000, AREA_SELECT_OE});
      for (int i = 0; i < 8; i++) begin
         if (i != 6) rreg(i[2:0], rst_val[i]);
      end
      wreg(REG_WIDTH, 8'h04);
      wreg(REG_STATES, 8'h0c);
      wreg(REG_WAITEN, 8'hff);
      foreach (rows[i]) begin
         wreg(REG_WAIT, rows[i].wait_ctrl_reg);
         wreg(REG_SYSCTL, {7'h00, rows[i].ram});
         MODE_16M <= rows[i].m16;
         stall <= rows[i].st;
         repeat (4) @(posedge CORE_CLK);
         acc(rows[i], d, n, s, t);
         if (!rows[i].wr && rows[i].wd) chk("word_data", rows[i].exp, d);
         if (!rows[i].wr && !rows[i].wd) chk("byte_data", rows[i].exp, {8'h00, d[7:0]});
         if (rows[i].cyc != 0) chk("cycles", rows[i].cyc[15:0], n[15:0]);
         chk("selects", {12'h000, rows[i].sel}, {12'h000, s});
         chk("strobes", {13'h0000, rows[i].strb}, {13'h0000, t});
      end
      rreg(REG_STATUS, 8'h02);
      stall <= 1'b0;
      MODE_16M <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         wreg(REG_WAITEN, i ? 8'hff : 8'hf7);
         wreg(REG_WAIT, i ? 8'hf9 : 8'hf0);
         stall <= 1'b1;
         // Let the wait request pass the synchroniser before T2
         repeat (4) @(posedge CORE_CLK);
         fork
            acc(rows[11], d, n, s, t);
            begin
               repeat (14) @(posedge CORE_CLK);
               stall <= 1'b0;
            end
         join
         chk("pin_wait", 16'h0001, {15'h0000, (n >= 13 && n <= 24)});
      end
      wreg(REG_SELDIR, 8'h0e);
      @(posedge CORE_CLK);
      chk("select_oe", 16'h000f, {12'h000, AREA_SELECT_OE});
      rreg(REG_SELDIR, 8'h0f);
      RESET <= 1'b1;
      repeat (4) @(posedge CORE_CLK);
      RESET <= 1'b0;
      rreg(REG_WAIT, 8'hf3);
      chk("select_oe", 16'h0001, {12'h000, AREA_SELECT_OE});
      end_of_test();
   end
endmodule
